/* acis_defs.vh */
// Constants for the amplifier control two-wire slave
`ifndef ACIS_DEFS_VH
`define ACIS_DEFS_VH
`define ACIS_ADDR_BASE      5'h1B
`define ACIS_STRAP_GND      2'h0
`define ACIS_STRAP_35PCT    2'h1
`define ACIS_STRAP_65PCT    2'h2
`define ACIS_STRAP_BYP      2'h3
`define ACIS_STRAP_WAIT     2'h2
`define ACIS_DIR_WRITE      1'h0
`define ACIS_DIR_READ       1'h1
`define ACIS_REG_STAT_LAST  8'h07
`define ACIS_REG_CTRL_FIRST 8'h08
`define ACIS_REG_CTRL_LAST  8'h0D
`define ACIS_REG_CTRL7      8'h10
`define ACIS_REG_STAT5      8'h13
`define ACIS_REG_GAIN       8'h08
`define ACIS_CTRL_RESET     8'h00
`define ACIS_GAIN_W         2
`define ACIS_SYNC_MAX_HZ    2500000
`define ACIS_CLK_HZ         100000000
`endif

/* acis_sync2.v */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module acis_sync2 #(
   parameter W = 1
) (
   input  wire         i_core_clk,
   input  wire         i_rst_n,
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta_q;
   // Meta stage feeds only the second stage
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         meta_q <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* acis_i2c_slave.v */
// Two-wire control port slave of a four-channel amplifier
`timescale 1ns/1ns
`default_nettype none
`include "acis_defs.vh"
module acis_i2c_slave (
   input  wire        i_core_clk,
   input  wire        i_rst_n,
   input  wire        i_scl,
   input  wire        i_sda,
   output reg         o_sda,
   output reg         o_sda_oe_n,
   input  wire [1:0]  i_addr_strap,
   input  wire [71:0] i_status,
   input  wire        i_oscillator_align_pin,
   output reg         o_osc_master,
   output reg         o_oscillator_align_pin,
   output reg         o_oscillator_align_oe_n,
   output reg         o_osc_tick,
   output reg  [7:0]  o_chan_gain,
   output reg  [55:0] o_ctrl,
   output reg         o_busy
);
   localparam ST_IDLE = 6'b000001;
   localparam ST_ADDR = 6'b000010;
   localparam ST_SUB  = 6'b000100;
   localparam ST_WDAT = 6'b001000;
   localparam ST_RDAT = 6'b010000;
   localparam ST_ACK  = 6'b100000;
   localparam integer SYNC_DIV = `ACIS_CLK_HZ / `ACIS_SYNC_MAX_HZ;

   wire [1:0] pins_s;
   wire [1:0] strap_s;
   wire       align_s;
   acis_sync2 #(.W(2)) u_bus_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    ({i_scl, i_sda}),
      .o_sync     (pins_s)
   );
   acis_sync2 #(.W(3)) u_pin_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    ({i_oscillator_align_pin, i_addr_strap}),
      .o_sync     ({align_s, strap_s})
   );

   reg  [1:0]  scl_q;
   reg  [1:0]  sda_q;
   reg  [5:0]  st_q;
   reg  [5:0]  ret_q;
   reg  [3:0]  bit_q;
   reg  [7:0]  shift_q;
   reg  [7:0]  ptr_q;
   reg         rd_q;
   reg         ack_drv_q;
   reg  [1:0]  strap_q;
   reg         strap_ok_q;
   reg  [1:0]  strap_wait_q;
   reg  [6:0]  ctrl_q [0:7];
   reg  [7:0]  ctrl_b_q [0:7];
   reg  [5:0]  div_q;
   reg         align_q;
   reg  [7:0]  rd_byte;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_c;
   wire        stop_c;
   wire [6:0]  own_addr;
   wire [2:0]  ctrl_idx;
   wire        ctrl_hit;

   assign scl_rise = scl_q[0] & ~scl_q[1];
   assign scl_fall = ~scl_q[0] & scl_q[1];
   // Conditions only while SCL is steady high
   assign start_c  = scl_q[0] & scl_q[1] & sda_q[1] & ~sda_q[0];
   assign stop_c   = scl_q[0] & scl_q[1] & ~sda_q[1] & sda_q[0];
   assign own_addr = {`ACIS_ADDR_BASE, strap_q};
   assign ctrl_hit = (ptr_q >= `ACIS_REG_CTRL_FIRST && ptr_q <= `ACIS_REG_CTRL_LAST)
                     || ptr_q == `ACIS_REG_CTRL7;
   assign ctrl_idx = (ptr_q == `ACIS_REG_CTRL7) ? 3'h6 : ptr_q[2:0];

   // Read mux: status, control, else zero
   always @* begin
      rd_byte = 8'h00;
      if (ptr_q <= `ACIS_REG_STAT_LAST)
         rd_byte = i_status[ptr_q[2:0]*8 +: 8];
      else if (ptr_q == `ACIS_REG_STAT5)
         rd_byte = i_status[71:64];
      else if (ctrl_hit)
         rd_byte = ctrl_b_q[ctrl_idx];
   end

   // Strap caught after reset release, then held
   // Wait until the synchroniser has flushed its reset zeros
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         strap_q      <= `ACIS_STRAP_GND;
         strap_ok_q   <= 1'b0;
         strap_wait_q <= 2'h0;
      end else if (!strap_ok_q) begin
         if (strap_wait_q == `ACIS_STRAP_WAIT) begin
            strap_q    <= strap_s;
            strap_ok_q <= 1'b1;
         end else begin
            strap_wait_q <= strap_wait_q + 2'h1;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ctrl
         always @(posedge i_core_clk) begin
            if (!i_rst_n)
               ctrl_b_q[g] <= `ACIS_CTRL_RESET;
            else if (st_q == ST_WDAT && bit_q == 4'h8 && scl_fall && ctrl_hit && ctrl_idx == g)
               ctrl_b_q[g] <= shift_q;
         end
         always @* ctrl_q[g] = ctrl_b_q[g][6:0];
      end
   endgenerate

   // Bus engine
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         scl_q      <= 2'h3;
         sda_q      <= 2'h3;
         st_q       <= ST_IDLE;
         ret_q      <= ST_IDLE;
         bit_q      <= 4'h0;
         shift_q    <= 8'h00;
         ptr_q      <= 8'h00;
         rd_q       <= 1'b0;
         ack_drv_q  <= 1'b0;
         o_sda      <= 1'b0;
         o_sda_oe_n <= 1'b1;
         o_busy     <= 1'b0;
      end else begin
         scl_q   <= {scl_q[0], pins_s[1]};
         sda_q   <= {sda_q[0], pins_s[0]};
         o_sda   <= 1'b0;
         o_busy  <= (st_q != ST_IDLE);
         if (start_c) begin
            st_q       <= ST_ADDR;
            bit_q      <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            st_q       <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
         end else begin
            case (st_q)
               ST_IDLE: o_sda_oe_n <= 1'b1;
               ST_ADDR, ST_SUB, ST_WDAT: begin
                  // Bits shift on rising edge, MSB first
                  if (scl_rise && bit_q < 4'h8) begin
                     shift_q <= {shift_q[6:0], sda_q[0]};
                     bit_q   <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (st_q == ST_ADDR) begin
                        if (shift_q[7:1] == own_addr) begin
                           rd_q       <= shift_q[0];
                           o_sda_oe_n <= 1'b0;
                           st_q       <= ST_ACK;
                           ret_q      <= (shift_q[0] == `ACIS_DIR_WRITE) ? ST_SUB : ST_RDAT;
                           if (shift_q[0] == `ACIS_DIR_READ)
                              shift_q <= rd_byte;
                        end else
                           st_q <= ST_IDLE;
                     end else begin
                        o_sda_oe_n <= 1'b0;
                        st_q       <= ST_ACK;
                        ret_q      <= ST_WDAT;
                        if (st_q == ST_SUB)
                           ptr_q <= shift_q;
                        else
                           ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               ST_ACK: begin
                  // Release at end of acknowledge clock, or put out the first bit on a read
                  if (scl_fall) begin
                     o_sda_oe_n <= 1'b1;
                     st_q       <= ret_q;
                     ack_drv_q  <= 1'b0;
                     if (ret_q == ST_RDAT) begin
                        o_sda_oe_n <= shift_q[7];
                        shift_q    <= {shift_q[6:0], 1'b0};
                        bit_q      <= 4'h1;
                     end
                  end
               end
               ST_RDAT: begin
                  if (scl_fall && bit_q < 4'h8) begin
                     o_sda_oe_n <= shift_q[7];
                     shift_q    <= {shift_q[6:0], 1'b0};
                     bit_q      <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     o_sda_oe_n <= 1'b1;
                     bit_q      <= 4'h9;
                  end else if (scl_rise && bit_q == 4'h9) begin
                     if (!sda_q[0]) begin
                        ptr_q   <= ptr_q + 8'h01;
                        ack_drv_q <= 1'b1;
                     end else
                        st_q <= ST_IDLE;
                  end else if (scl_fall && bit_q == 4'h9 && ack_drv_q) begin
                     shift_q    <= {rd_byte[6:0], 1'b0};
                     o_sda_oe_n <= rd_byte[7];
                     bit_q      <= 4'h1;
                     ack_drv_q  <= 1'b0;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // SCL is never driven: no clock stretching

   // Gains and control outputs from registers
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_chan_gain <= 8'h00;
         o_ctrl      <= 56'h0;
      end else begin
         o_chan_gain <= ctrl_b_q[0];
         // Bit 48 is spare and reads zero
         o_ctrl      <= {ctrl_q[6], 1'b0, ctrl_b_q[5], ctrl_b_q[4], ctrl_b_q[3],
                         ctrl_b_q[2], ctrl_b_q[1], ctrl_b_q[0][7:0]};
      end
   end

   // Oscillator alignment: master drives pulses, slaves follow pin
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         div_q                   <= 6'h00;
         align_q                 <= 1'b0;
         o_osc_master            <= 1'b0;
         o_oscillator_align_pin  <= 1'b0;
         o_oscillator_align_oe_n <= 1'b1;
         o_osc_tick              <= 1'b0;
      end else begin
         align_q      <= align_s;
         o_osc_master <= strap_ok_q && strap_q == `ACIS_STRAP_GND;
         o_oscillator_align_pin <= 1'b0;
         if (o_osc_master) begin
            div_q <= (div_q == SYNC_DIV[5:0] - 6'h01) ? 6'h00 : div_q + 6'h01;
            o_oscillator_align_oe_n <= (div_q >= SYNC_DIV[5:0] / 6'h02);
            o_osc_tick <= (div_q == 6'h00);
         end else begin
            o_oscillator_align_oe_n <= 1'b1;
            o_osc_tick <= align_s & ~align_q;
         end
      end
   end
endmodule
`default_nettype wire

/* acis_bus_properties.sv */
// Assertions on the amplifier control port slave
`timescale 1ns/1ns
`default_nettype none
module acis_props (
   input wire logic       i_core_clk,
   input wire logic       i_rst_n,
   input wire logic       i_scl,
   input wire logic       i_sda,
   input wire logic [1:0] i_addr_strap,
   input wire logic       o_sda,
   input wire logic       o_sda_oe_n,
   input wire logic       o_osc_master,
   input wire logic       o_oscillator_align_oe_n,
   input wire logic       o_osc_tick,
   input wire logic       o_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Cycles since reset release, saturating; strap is captured late
   logic [2:0] up_q;
   always_ff @(posedge i_core_clk) up_q <= !i_rst_n ? 3'h0 : up_q + 3'(up_q != 3'h7);
   sequence s_pull; $fell(o_sda_oe_n); endsequence
   sequence s_clk_hi; ##[1:12] $rose(i_scl); endsequence
   property p_only_low; !o_sda; endproperty
   property p_low_change; $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl); endproperty
   property p_pull_bit; s_pull |-> s_clk_hi; endproperty
   property p_idle_free; !o_busy |-> o_sda_oe_n; endproperty
   property p_stop_idle; i_scl && $rose(i_sda) |-> ##[1:8] !o_busy; endproperty
   property p_role; up_q == 3'h7 |-> o_osc_master == (i_addr_strap == 2'h0); endproperty
   property p_align_slave; !o_osc_master |-> o_oscillator_align_oe_n; endproperty
   property p_align_period;
      $fell(o_oscillator_align_oe_n) |-> ##20 $rose(o_oscillator_align_oe_n) ##20 $fell(o_oscillator_align_oe_n);
   endproperty
   property p_tick; o_osc_tick |=> !o_osc_tick; endproperty
   a_only_low: assert property (p_only_low) else $error("data pin driven high");
   a_low_change: assert property (p_low_change) else $error("data moved with clock high");
   a_pull_bit: assert property (p_pull_bit) else $error("pull not followed by clock");
   a_idle_free: assert property (p_idle_free) else $error("data held while idle");
   a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
   a_role: assert property (p_role) else $error("oscillator role wrong");
   a_align_slave: assert property (p_align_slave) else $error("slave drives align pin");
   a_align_period: assert property (p_align_period) else $error("align period wrong");
   a_tick: assert property (p_tick) else $error("tick too long");
endmodule
bind acis_i2c_slave acis_props i_acis_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
   .i_sda(i_sda), .i_addr_strap(i_addr_strap), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
   .o_osc_master(o_osc_master), .o_oscillator_align_oe_n(o_oscillator_align_oe_n),
   .o_osc_tick(o_osc_tick), .o_busy(o_busy));
`default_nettype wire

/* acis_bus_master.sv */
// Behavioural two-wire bus master driving the control port
`timescale 1ns/1ns
`default_nettype none
module acis_bus_master (
   input  wire logic i_core_clk,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_low
);
   // Clock idles high between frames; 13-cycle bit period
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // Start or repeated start
   task automatic start;
      o_sda_low <= 1'b0;
      tk(4);
      o_scl <= 1'b1;
      tk(6);
      o_sda_low <= 1'b1;
      tk(6);
      o_scl <= 1'b0;
      tk(3);
   endtask
   // Data set while clock low, sampled at end of high
   task automatic clk_bit(input logic b, output logic r);
      o_sda_low <= !b;
      tk(4);
      o_scl <= 1'b1;
      tk(6);
      r = i_sda;
      o_scl <= 1'b0;
      tk(3);
   endtask
   // MSB first, ninth clock is the acknowledge
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ar);
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
      clk_bit(a, ar);
   endtask
   // Stop
   task automatic stop;
      o_sda_low <= 1'b1;
      tk(4);
      o_scl <= 1'b1;
      tk(6);
      o_sda_low <= 1'b0;
      tk(10);
   endtask
endmodule
`default_nettype wire

/* tb_amp_control_i2c_slave.sv */
// Self-checking bench for the amplifier control port slave
`timescale 1ns/1ns
`default_nettype none
`include "acis_defs.vh"
module tb_amp_control_i2c_slave;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  strap = 2'h0;
   logic [71:0] stat = 72'h0;
   logic        align = 1'b0;
   wire         scl, m_low, oe_n, d_sda, busy, osc_m;
   wire  [7:0]  gain;
   wire  [55:0] ctrl;
   logic [7:0]  regs [0:255];
   logic [7:0]  q;
   logic        a;
   int          err_count = 0;
   int          comparisons = 0;
   // Open-drain wire with pull-up
   wire sda = !m_low && (oe_n || d_sda);
   always #5 clk = !clk;
   always @(posedge clk) align <= 1'($urandom);
   acis_i2c_slave i_acis_i2c_slave (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda(d_sda), .o_sda_oe_n(oe_n), .i_addr_strap(strap), .i_status(stat),
      .i_oscillator_align_pin(align), .o_osc_master(osc_m), .o_oscillator_align_pin(),
      .o_oscillator_align_oe_n(), .o_osc_tick(), .o_chan_gain(gain), .o_ctrl(ctrl), .o_busy(busy));
   acis_bus_master i_acis_bus_master (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [7:0] exp_rd(input logic [7:0] r);
      if (r <= 8'h07) return stat[8*r+:8];
      if (r == 8'h13) return stat[71:64];
      return regs[r];
   endfunction
   task automatic reset_to(input logic [1:0] s);
      rst_n <= 1'b0;
      strap <= s;
      stat[31:0] <= $urandom;
      stat[63:32] <= $urandom;
      stat[71:64] <= 8'($urandom);
      foreach (regs[i]) regs[i] = 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   // Write nw bytes from sub, then read nr bytes after a repeated start
   task automatic xact(input logic wrong, input logic [7:0] sub, input int nw, input int nr);
      logic [7:0] d;
      logic [7:0] dev;
      dev = {`ACIS_ADDR_BASE, wrong ? ~strap : strap, 1'b0};
      i_acis_bus_master.start;
      i_acis_bus_master.xfer(dev, 1'b1, q, a);
      chk(a, wrong);
      if (!wrong) begin
         i_acis_bus_master.xfer(sub, 1'b1, q, a);
         chk(a, 1'b0);
         for (int k = 0; k < nw; k++) begin
            d = $urandom;
            if (sub inside {[8'h08:8'h0D], 8'h10}) regs[sub] = d;
            i_acis_bus_master.xfer(d, 1'b1, q, a);
            chk(a, 1'b0);
            sub++;
         end
         if (nr > 0) begin
            i_acis_bus_master.start;
            i_acis_bus_master.xfer(dev | 8'h01, 1'b1, q, a);
            chk(a, 1'b0);
            for (int k = 0; k < nr; k++) begin
               i_acis_bus_master.xfer(8'hFF, k == nr - 1, q, a);
               chk(q, exp_rd(sub));
               sub++;
            end
         end
      end
      i_acis_bus_master.stop;
      chk({busy, oe_n}, 2'h1);
   endtask
   initial begin
      void'($urandom(78417));
      // Last pass leaves the part as oscillator master
      for (int s = 3; s >= 0; s--) begin
         reset_to(2'(s));
         chk(osc_m, s == 0);
         xact(1'b1, 8'h08, 1, 0);
         xact(1'b0, 8'h08, 1, 0);
         chk(gain, regs[8]);
      end
      xact(1'b0, 8'h06, 11, 0);
      for (int r = 0; r < 6; r++) chk(ctrl[8*r+:8], regs[8+r]);
      chk(ctrl[55:49], regs[8'h10][6:0]);
      xact(1'b0, 8'h00, 0, 20);
      repeat (6) xact(1'b0, 8'($urandom_range(0, 19)), $urandom_range(0, 3), $urandom_range(1, 4));
      test_done;
   end
   // Whole run needs well under 400 us; a hang stops here
   initial begin
      #800000;
      err_count++;
      test_done;
   end
endmodule
`default_nettype wire
